/* logic/dtm_map.vh */
// register offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DTM_MAP_VH
`define DTM_MAP_VH
`define DTM_ADDR_MODE 8'h89
`define DTM_ADDR_CTRL 8'h80
`define DTM_ADDR_STATUS 8'h81
`define DTM_ADDR_MASK 8'h82
`define DTM_ADDR_T0_LOW 8'h84
`define DTM_ADDR_T0_HIGH 8'h85
`define DTM_ADDR_T1_LOW 8'h86
`define DTM_ADDR_T1_HIGH 8'h87
`define DTM_MODE_RESET 8'h00
`define DTM_CTRL_RESET 8'h00
`define DTM_STATUS_RESET 2'h0
`define DTM_MASK_RESET 2'h0
`define DTM_COUNT_RESET 8'h00
`define DTM_BIT_T1_GATE 7
`define DTM_BIT_T1_SRC 6
`define DTM_BIT_T1_MODE_HI 5
`define DTM_BIT_T1_MODE_LO 4
`define DTM_BIT_T0_GATE 3
`define DTM_BIT_T0_SRC 2
`define DTM_BIT_T0_MODE_HI 1
`define DTM_BIT_T0_MODE_LO 0
`define DTM_BIT_T0_RUN 0
`define DTM_BIT_T1_RUN 1
`define DTM_BIT_IRQ_A_POL 2
`define DTM_BIT_IRQ_B_POL 3
`define DTM_BIT_T0_PRESCALE 4
`define DTM_BIT_T1_PRESCALE 5
`define DTM_BIT_FLAG_T0 0
`define DTM_BIT_FLAG_T1 1
`define DTM_MODE_13BIT 2'h0
`define DTM_MODE_16BIT 2'h1
`define DTM_MODE_RELOAD 2'h2
`define DTM_MODE_SPLIT 2'h3
`define DTM_PRESCALE_DIV 4'hC
`endif

/* logic/dtm_timer_mode_config.v */
// dual counter/timer with mode configuration register, run control, flags and interrupt
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "dtm_map.vh"

module dtm_timer_mode_config (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire count_input_pin_a,
  input wire count_input_pin_b,
  input wire ext_irq_a_input,
  input wire ext_irq_b_input,
  output reg irq,
  output reg timer0_overflow_pulse,
  output reg timer1_overflow_pulse
);

  // one counting step for modes 0 to 2: {overflow, next value}
  function [16:0] dtm_step;
    input [1:0] mode;
    input [15:0] value;
    reg [12:0] low13;
    begin
      low13 = {value[15:8], value[4:0]} + 13'h0001;
      dtm_step = {1'b0, value};
      case (mode)
        `DTM_MODE_13BIT: begin
          dtm_step = {(&{value[15:8], value[4:0]}), low13[12:5], value[7:5], low13[4:0]};
        end
        `DTM_MODE_16BIT: begin
          dtm_step = {(&value), value + 16'h0001};
        end
        `DTM_MODE_RELOAD: begin
          if (&value[7:0]) begin
            dtm_step = {1'b1, value[15:8], value[15:8]};
          end else begin
            dtm_step = {1'b0, value[15:8], value[7:0] + 8'h01};
          end
        end
        default: begin
          dtm_step = {1'b0, value};
        end
      endcase
    end
  endfunction

  // a strobe that lands on one register offset
  function dtm_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      dtm_hit = strobe & (addr == offset);
    end
  endfunction

  reg [7:0] timer_mode_config;
  reg [7:0] run_control;
  reg [1:0] flag_status;
  reg [1:0] flag_mask;
  reg [7:0] t0_low;
  reg [7:0] t0_high;
  reg [7:0] t1_low;
  reg [7:0] t1_high;
  reg [3:0] prescale_count;
  reg prescale_tick;
  reg [3:0] sync_first;
  reg [3:0] sync_second;
  reg [3:0] sync_last;

  reg [7:0] next_t0_low;
  reg [7:0] next_t0_high;
  reg [7:0] next_t1_low;
  reg [7:0] next_t1_high;
  reg t0_overflow;
  reg t0_high_overflow;
  reg t1_overflow;
  reg [16:0] t0_result;
  reg [16:0] t1_result;

  wire [1:0] t0_mode;
  wire [1:0] t1_mode;
  wire t0_split;
  wire irq_a_active;
  wire irq_b_active;
  wire fall_a;
  wire fall_b;
  wire tick0;
  wire tick1;
  wire t0_running;
  wire t1_running;
  wire t0_count;
  wire t0_high_count;
  wire t1_count;
  wire wr_status;
  wire [1:0] flag_set;
  // per-register write strobes
  wire wr_mode;
  wire wr_ctrl;
  wire wr_mask;
  wire wr_t0_low;
  wire wr_t0_high;
  wire wr_t1_low;
  wire wr_t1_high;

  // mode fields of both timers
  assign t0_mode = {timer_mode_config[`DTM_BIT_T0_MODE_HI], timer_mode_config[`DTM_BIT_T0_MODE_LO]};
  assign t1_mode = {timer_mode_config[`DTM_BIT_T1_MODE_HI], timer_mode_config[`DTM_BIT_T1_MODE_LO]};
  assign t0_split = (t0_mode == `DTM_MODE_SPLIT);

  // bit order in the synchroniser: 0 pin a, 1 pin b, 2 irq a, 3 irq b
  assign fall_a = sync_last[0] & ~sync_second[0];
  assign fall_b = sync_last[1] & ~sync_second[1];
  assign irq_a_active = ~(sync_second[2] ^ run_control[`DTM_BIT_IRQ_A_POL]);
  assign irq_b_active = ~(sync_second[3] ^ run_control[`DTM_BIT_IRQ_B_POL]);

  // prescale select 1 picks the system clock, 0 the divided tick
  assign tick0 = run_control[`DTM_BIT_T0_PRESCALE] | prescale_tick;
  assign tick1 = run_control[`DTM_BIT_T1_PRESCALE] | prescale_tick;

  // gate 1 lets the external input hold timer 0 off
  assign t0_running = run_control[`DTM_BIT_T0_RUN] &
                      (~timer_mode_config[`DTM_BIT_T0_GATE] | irq_a_active);
  assign t0_count = t0_running &
                    (timer_mode_config[`DTM_BIT_T0_SRC] ? fall_a : tick0);

  // split timer 0 high half borrows timer 1 run bit and counts the internal clock only
  assign t0_high_count = t0_split & run_control[`DTM_BIT_T1_RUN] & tick0;

  // timer 1 ignores its run bit while timer 0 is split; its own mode 3 holds it
  assign t1_running = (t1_mode != `DTM_MODE_SPLIT) & (t0_split | (run_control[`DTM_BIT_T1_RUN] &
                      (~timer_mode_config[`DTM_BIT_T1_GATE] | irq_b_active)));
  assign t1_count = t1_running &
                    ((timer_mode_config[`DTM_BIT_T1_SRC] & ~t0_split) ? fall_b : tick1);

  // next counter values and overflow strobes of both timers
  always @* begin
    t0_result = dtm_step(t0_mode, {t0_high, t0_low});
    t1_result = dtm_step(t1_mode, {t1_high, t1_low});
    next_t0_low = t0_low;
    next_t0_high = t0_high;
    next_t1_low = t1_low;
    next_t1_high = t1_high;
    t0_overflow = 1'b0;
    t0_high_overflow = 1'b0;
    t1_overflow = 1'b0;
    if (t0_split) begin
      if (t0_count) begin
        next_t0_low = t0_low + 8'h01;
        t0_overflow = &t0_low;
      end
      if (t0_high_count) begin
        next_t0_high = t0_high + 8'h01;
        t0_high_overflow = &t0_high;
      end
    end else if (t0_count) begin
      next_t0_low = t0_result[7:0];
      next_t0_high = t0_result[15:8];
      t0_overflow = t0_result[16];
    end
    if (t1_count) begin
      next_t1_low = t1_result[7:0];
      next_t1_high = t1_result[15:8];
      t1_overflow = t1_result[16];
    end
  end

  // timer 1 overflow raises no flag while timer 0 is split; split high half raises it instead
  assign flag_set[`DTM_BIT_FLAG_T0] = t0_overflow;
  assign flag_set[`DTM_BIT_FLAG_T1] = (t1_overflow & ~t0_split) | t0_high_overflow;
  assign wr_status = dtm_hit(reg_write, reg_addr, `DTM_ADDR_STATUS);

  // write decode for the configuration and count registers
  assign wr_mode = dtm_hit(reg_write, reg_addr, `DTM_ADDR_MODE);
  assign wr_ctrl = dtm_hit(reg_write, reg_addr, `DTM_ADDR_CTRL);
  assign wr_mask = dtm_hit(reg_write, reg_addr, `DTM_ADDR_MASK);
  assign wr_t0_low = dtm_hit(reg_write, reg_addr, `DTM_ADDR_T0_LOW);
  assign wr_t0_high = dtm_hit(reg_write, reg_addr, `DTM_ADDR_T0_HIGH);
  assign wr_t1_low = dtm_hit(reg_write, reg_addr, `DTM_ADDR_T1_LOW);
  assign wr_t1_high = dtm_hit(reg_write, reg_addr, `DTM_ADDR_T1_HIGH);

  // two flops against metastability, the third keeps the last level for edge detection
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_first <= 4'h0;
      sync_second <= 4'h0;
      sync_last <= 4'h0;
    end else begin
      sync_first <= {ext_irq_b_input, ext_irq_a_input, count_input_pin_b, count_input_pin_a};
      sync_second <= sync_first;
      sync_last <= sync_second;
    end
  end

  // divided internal tick, one pulse per prescale period
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale_count <= 4'h0;
      prescale_tick <= 1'b0;
    end else if (prescale_count == `DTM_PRESCALE_DIV - 4'h1) begin
      prescale_count <= 4'h0;
      prescale_tick <= 1'b1;
    end else begin
      prescale_count <= prescale_count + 4'h1;
      prescale_tick <= 1'b0;
    end
  end

  // configuration registers; control bits 7:6 do not exist and read back as zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_mode_config <= `DTM_MODE_RESET;
      run_control <= `DTM_CTRL_RESET;
      flag_mask <= `DTM_MASK_RESET;
    end else if (wr_mode) begin
      timer_mode_config <= reg_wdata;
    end else if (wr_ctrl) begin
      run_control <= {2'h0, reg_wdata[5:0]};
    end else if (wr_mask) begin
      flag_mask <= reg_wdata[1:0];
    end
  end

  // software writes to a count byte take priority over counting in that cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      t0_low <= `DTM_COUNT_RESET;
      t0_high <= `DTM_COUNT_RESET;
      t1_low <= `DTM_COUNT_RESET;
      t1_high <= `DTM_COUNT_RESET;
    end else begin
      t0_low <= wr_t0_low ? reg_wdata : next_t0_low;
      t0_high <= wr_t0_high ? reg_wdata : next_t0_high;
      t1_low <= wr_t1_low ? reg_wdata : next_t1_low;
      t1_high <= wr_t1_high ? reg_wdata : next_t1_high;
    end
  end

  // write one to clear; a new overflow in the same cycle keeps the flag set
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_status <= `DTM_STATUS_RESET;
    end else begin
      flag_status <= (flag_status & ~(wr_status ? reg_wdata[1:0] : 2'h0)) | flag_set;
    end
  end

  // every output leaves from a flop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
      timer0_overflow_pulse <= 1'b0;
      timer1_overflow_pulse <= 1'b0;
    end else begin
      irq <= |(flag_status & flag_mask);
      timer0_overflow_pulse <= t0_overflow;
      // still drives baud and conversion timing while timer 0 is split
      timer1_overflow_pulse <= t1_overflow;
    end
  end

  // read data stand only in the cycle after the read strobe, zero otherwise
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `DTM_ADDR_MODE) begin
        reg_rdata <= timer_mode_config;
      end else if (reg_addr == `DTM_ADDR_CTRL) begin
        reg_rdata <= run_control;
      end else if (reg_addr == `DTM_ADDR_STATUS) begin
        reg_rdata <= {6'h00, flag_status};
      end else if (reg_addr == `DTM_ADDR_MASK) begin
        reg_rdata <= {6'h00, flag_mask};
      end else if (reg_addr == `DTM_ADDR_T0_LOW) begin
        reg_rdata <= t0_low;
      end else if (reg_addr == `DTM_ADDR_T0_HIGH) begin
        reg_rdata <= t0_high;
      end else if (reg_addr == `DTM_ADDR_T1_LOW) begin
        reg_rdata <= t1_low;
      end else if (reg_addr == `DTM_ADDR_T1_HIGH) begin
        reg_rdata <= t1_high;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* testbench/dtm_properties.sv */
// concurrent checks on the dual timer block ports
`timescale 1ns/1ps
module dtm_properties (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire ext_irq_a_input,
  input wire irq,
  input wire timer0_overflow_pulse,
  input wire timer1_overflow_pulse
);
  reg [7:0] mode;
  reg [5:0] ctrl;
  reg [1:0] mask;
  reg [3:0] gate_idle;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= 8'h00;
      ctrl <= 6'h00;
      mask <= 2'h0;
      gate_idle <= 4'h0;
    end else begin
      if (reg_write && reg_addr == 8'h89)
        mode <= reg_wdata;
      if (reg_write && reg_addr == 8'h80)
        ctrl <= reg_wdata[5:0];
      if (reg_write && reg_addr == 8'h82)
        mask <= reg_wdata[1:0];
      // timer 0 held off by its gate input
      if (reg_write || !mode[3] || ext_irq_a_input == ctrl[2])
        gate_idle <= 4'h0;
      else if (gate_idle != 4'hF)
        gate_idle <= gate_idle + 4'h1;
    end
  end
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_MODE_READ: assert property (reg_read && reg_addr == 8'h89 |=> reg_rdata == mode)
    else $error("mode register readback wrong");
  AST_CTRL_READ: assert property (reg_read && reg_addr == 8'h80 |=> reg_rdata == {2'h0, ctrl})
    else $error("control register readback wrong");
  AST_UNMAPPED: assert property (reg_read && reg_addr == 8'h88 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_T0_STOPPED: assert property (!ctrl[0] && !$past(ctrl[0]) && !$past(ctrl[0], 2) |->
    !timer0_overflow_pulse) else $error("timer 0 overflow while stopped");
  AST_T0_GATED: assert property (gate_idle > 4'h5 |-> !timer0_overflow_pulse)
    else $error("timer 0 overflow while gate closed");
  AST_T1_OFF: assert property (mode[5:4] == 2'h3 && $past(mode[5:4]) == 2'h3 &&
    $past(mode[5:4], 2) == 2'h3 |-> !timer1_overflow_pulse) else $error("timer 1 ran in mode 3");
  AST_IRQ_MASKED: assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule
bind dtm_timer_mode_config dtm_properties u_props (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .ext_irq_a_input(ext_irq_a_input), .irq(irq), .timer0_overflow_pulse(timer0_overflow_pulse),
  .timer1_overflow_pulse(timer1_overflow_pulse));

/* testbench/dtm_timer_mode_config_bench.sv */
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`include "dtm_map.vh"
module dtm_timer_mode_config_bench;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg pin_a = 1'b0;
  reg pin_b = 1'b0;
  reg irq_a = 1'b0;
  reg irq_b = 1'b0;
  wire [7:0] reg_rdata;
  wire irq;
  wire ovf0;
  wire ovf1;
  reg [15:0] v;
  integer num_errors = 0;
  integer n_compared = 0;
  integer seed = 29;
  integer i;
  integer n;
  reg [7:0] d;
  dtm_timer_mode_config uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .count_input_pin_a(pin_a),
    .count_input_pin_b(pin_b), .ext_irq_a_input(irq_a), .ext_irq_b_input(irq_b), .irq(irq),
    .timer0_overflow_pulse(ovf0), .timer1_overflow_pulse(ovf1));
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // 13-bit mode: high byte sits above the low five bits, low bits 7:5 untouched
  function [15:0] step13(input [15:0] val);
    reg [12:0] c;
    begin
      c = {val[15:8], val[4:0]} + 13'h0001;
      step13 = {c[12:5], val[7:5], c[4:0]};
    end
  endfunction
  // k falling edges on count pin a or b
  task pin_falls(input b, input [7:0] k);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1) begin
        @(posedge clk);
        if (b)
          pin_b <= 1'b1;
        else
          pin_a <= 1'b1;
        repeat (4) @(posedge clk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        repeat (3) @(posedge clk);
      end
      repeat (6) @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #40000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(`DTM_ADDR_MODE);
    chk("reset", `DTM_MODE_RESET, d);
    for (i = 0; i < 4; i = i + 1) begin
      n = $random(seed);
      wr(`DTM_ADDR_MODE, n[7:0]);
      rd(`DTM_ADDR_MODE);
      chk("mode", n[7:0], d);
    end
    $display("register test done");
    wr(`DTM_ADDR_MASK, 8'h01);
    wr(`DTM_ADDR_MODE, 8'h02);
    wr(`DTM_ADDR_T0_HIGH, 8'h80);
    wr(`DTM_ADDR_T0_LOW, 8'hFC);
    wr(`DTM_ADDR_CTRL, 8'h11);
    for (n = 0; n < 50 && ovf0 !== 1'b1; n = n + 1) begin
      @(posedge clk);
      #1;
    end
    chk("ovf", 8'h01, {7'h00, ovf0});
    repeat (3) @(posedge clk);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`DTM_ADDR_CTRL, 8'h00);
    rd(`DTM_ADDR_T0_LOW);
    chk("reload", 8'h08, {4'h0, d[7:4]});
    rd(`DTM_ADDR_T0_HIGH);
    chk("reloadhi", 8'h80, d);
    wr(`DTM_ADDR_STATUS, 8'h01);
    rd(`DTM_ADDR_STATUS);
    chk("status", 8'h00, d);
    chk("irq off", 8'h00, {7'h00, irq});
    $display("reload test done");
    wr(`DTM_ADDR_MODE, 8'h05);
    wr(`DTM_ADDR_T0_LOW, 8'h00);
    wr(`DTM_ADDR_T0_HIGH, 8'h00);
    wr(`DTM_ADDR_CTRL, 8'h01);
    n = ($random(seed) & 7) + 1;
    pin_falls(1'b0, n[7:0]);
    rd(`DTM_ADDR_T0_LOW);
    chk("edges", n[7:0], d);
    wr(`DTM_ADDR_MODE, 8'h04);
    wr(`DTM_ADDR_T0_HIGH, 8'h00);
    wr(`DTM_ADDR_T0_LOW, 8'hFF);
    pin_falls(1'b0, 8'h01);
    v = step13(16'h00FF);
    rd(`DTM_ADDR_T0_LOW);
    chk("13b low", v[7:0], d);
    rd(`DTM_ADDR_T0_HIGH);
    chk("13b high", v[15:8], d);
    wr(`DTM_ADDR_CTRL, 8'h02);
    wr(`DTM_ADDR_MODE, 8'hD0);
    wr(`DTM_ADDR_T1_LOW, 8'h00);
    wr(`DTM_ADDR_T1_HIGH, 8'h00);
    @(posedge clk);
    irq_b <= 1'b1;
    pin_falls(1'b1, 8'h02);
    rd(`DTM_ADDR_T1_LOW);
    chk("t1 gated", 8'h00, d);
    @(posedge clk);
    irq_b <= 1'b0;
    pin_falls(1'b1, 8'h03);
    rd(`DTM_ADDR_T1_LOW);
    chk("t1 edges", 8'h03, d);
    $display("pin test done");
    wr(`DTM_ADDR_MODE, 8'h09);
    wr(`DTM_ADDR_CTRL, 8'h15);
    rd(`DTM_ADDR_CTRL);
    chk("ctrl", 8'h15, d);
    wr(`DTM_ADDR_T0_LOW, 8'h00);
    repeat (20) @(posedge clk);
    rd(`DTM_ADDR_T0_LOW);
    chk("gated", 8'h00, d);
    @(posedge clk);
    irq_a <= 1'b1;
    repeat (20) @(posedge clk);
    rd(`DTM_ADDR_T0_LOW);
    chk("open", 8'h01, {7'h00, d != 8'h00});
    $display("gate test done");
    wr(`DTM_ADDR_MODE, 8'h30);
    wr(`DTM_ADDR_CTRL, 8'h22);
    wr(`DTM_ADDR_T1_HIGH, 8'hFF);
    wr(`DTM_ADDR_T1_LOW, 8'hF0);
    repeat (20) @(posedge clk);
    rd(`DTM_ADDR_T1_LOW);
    chk("t1 off", 8'hF0, d);
    rd(8'h88);
    chk("unmapped", 8'h00, d);
    wr(`DTM_ADDR_MODE, 8'h13);
    wr(`DTM_ADDR_CTRL, 8'h31);
    wr(`DTM_ADDR_T0_HIGH, 8'h00);
    wr(`DTM_ADDR_STATUS, 8'h03);
    wr(`DTM_ADDR_T1_LOW, 8'hF0);
    for (n = 0; n < 40 && ovf1 !== 1'b1; n = n + 1) begin
      @(posedge clk);
      #1;
    end
    chk("t1 ovf", 8'h01, {7'h00, ovf1});
    rd(`DTM_ADDR_T1_LOW);
    chk("t1 runs", 8'h01, {7'h00, d != 8'h00});
    rd(`DTM_ADDR_STATUS);
    chk("t1 flag", 8'h00, {7'h00, d[1]});
    rd(`DTM_ADDR_T0_HIGH);
    chk("split", 8'h00, d);
    wr(`DTM_ADDR_CTRL, 8'h33);
    repeat (20) @(posedge clk);
    rd(`DTM_ADDR_T0_HIGH);
    chk("split hi", 8'h01, {7'h00, d != 8'h00});
    $display("mode 3 test done");
    final_report;
  end
endmodule
